// >>> hw/bss_pkg.sv
// package: constants, register map and types for the burner state sequencer block
package bss_pkg;

    // apb register byte offsets
    localparam logic [7:0] BSS_CTRL_OFS = 8'h00;
    localparam logic [7:0] BSS_STAT_OFS = 8'h04;
    localparam logic [7:0] BSS_IRQ_OFS = 8'h08;
    localparam logic [7:0] BSS_MASK_OFS = 8'h0C;
    localparam logic [7:0] BSS_DLY_OFS = 8'h10;
    localparam logic [7:0] BSS_RELIGHT_OFS = 8'h14;

    // ctrl register field positions
    localparam int BSS_CTRL_RUN = 0;
    localparam int BSS_CTRL_POFF = 1;   // 2 bits
    localparam int BSS_CTRL_AUXPID = 3;
    localparam int BSS_CTRL_LHS = 4;    // 0 wait, 1 main permissive
    localparam int BSS_CTRL_REIGN = 5;

    // reset values
    localparam logic [31:0] BSS_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] BSS_DLY_RST = 32'h0000_03E8;
    localparam logic [3:0] BSS_RELIGHT_RST = 4'h3;

    // irq bit positions
    localparam int BSS_IRQ_LOCKOUT = 0;
    localparam int BSS_IRQ_WAIT = 1;
    localparam int BSS_IRQ_PILOT = 2;
    localparam int BSS_IRQ_CHANGE = 3;
    localparam int BSS_IRQ_W = 4;

    // pilot-off mode setting
    typedef enum logic [1:0] {
        BSS_POFF_DISABLED,
        BSS_POFF_AT_SETPOINT,
        BSS_POFF_AFTER_MAIN,
        BSS_POFF_FOLLOW_MAIN
    } bss_poff_t;

    // sequencer states covered here plus their neighbours
    typedef enum logic [2:0] {
        BSS_ST_LOCKOUT,
        BSS_ST_WAITING,
        BSS_ST_PILOT,
        BSS_ST_LOW_FIRE,
        BSS_ST_INCIN,
        BSS_ST_INCIN_NA,
        BSS_ST_PID
    } bss_state_t;

    // process comparisons and conditions from the rest of the controller
    typedef struct packed {
        logic above_assist_off;
        logic above_waste_off;
        logic below_process_sp;
        logic above_low_fire_sp;
        logic alarm;
        logic wait_cond;
        logic main_perm;
        logic flame_loss;
        logic [3:0] relight_count;
    } bss_cond_t;

    // safety outputs
    typedef struct packed {
        logic pilot;
        logic first_safety_shutoff_valve;
        logic second_safety_shutoff_valve;
        logic card_valve;
        logic ign_coil;
        logic uv_ign_enable;
    } bss_out_t;

endpackage

// >>> hw/bss_seq.sv
// burner state sequencer: incinerate-no-assist and pid control states with apb registers
// Summary of operation
// - incin-no-assist: pilot on, first valve off, second on
// - card valve on; coil, uv enable only reigniting
// - pilot-off-after-main drops pilot and card valve
// - pid control: pilot and both valves on
// - incinerate to no-assist above assist-off, clean
// - alarm forces lockout
// - user stop forces lockout
// - flame loss, relights exceeded: lockout
// - flame loss, relights remaining: waiting
// - wait condition forces waiting
// - main permissive: waiting or pilot per mode
// - no-assist above waste-off: waiting or pilot per mode
// - no-assist back to incinerate below assist-off
// - low fire to pid below setpoint, aux pid
// - pid standby band, delay elapsed, wait mode: waiting
// - pid standby band, delay elapsed, permissive mode: pilot
// - pid above low-fire setpoint: waiting or pilot
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bss_seq
    import bss_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // process conditions, same clock domain
    input wire bss_cond_t cond,
    // state entry from the rest of the sequencer
    input wire logic enter_valid,
    input wire bss_state_t enter_state,
    // safety outputs and status
    output bss_out_t safety,
    output bss_state_t state,
    output logic irq
);

    // whole module state
    typedef struct packed {
        bss_state_t st;
        bss_out_t out;
        logic [31:0] ctrl;
        logic [31:0] dly;
        logic [3:0] relight_max;
        logic [31:0] dly_cnt;
        logic [BSS_IRQ_W-1:0] irq_st;
        logic [BSS_IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic irq;
    } bss_reg_t;

    bss_reg_t r_q;
    bss_reg_t r_d;

    // true when the register offset is mapped
    function automatic logic bss_mapped(input logic [7:0] a);
        return a == BSS_CTRL_OFS || a == BSS_STAT_OFS || a == BSS_IRQ_OFS ||
               a == BSS_MASK_OFS || a == BSS_DLY_OFS || a == BSS_RELIGHT_OFS;
    endfunction

    // pilot-off setting that sends main-side exits to waiting
    function automatic logic bss_poff_to_wait(input logic [1:0] m);
        return m == BSS_POFF_AFTER_MAIN || m == BSS_POFF_FOLLOW_MAIN;
    endfunction

    logic acc;
    logic [1:0] poff;
    logic clean;
    logic lock_go;
    logic wait_go;
    bss_state_t nx;
    logic in_main;

    always_comb begin
        r_d = r_q;
        acc = psel && penable && !r_q.ready;
        poff = r_q.ctrl[BSS_CTRL_POFF +: 2];
        clean = !cond.alarm && !cond.wait_cond && !cond.main_perm;
        in_main = r_q.st == BSS_ST_INCIN_NA || r_q.st == BSS_ST_PID;
        // lockout causes first, then waiting causes, then temperature
        lock_go = cond.alarm || !r_q.ctrl[BSS_CTRL_RUN] ||
                  (cond.flame_loss && cond.relight_count > r_q.relight_max);
        wait_go = cond.wait_cond || cond.flame_loss;
        nx = r_q.st;

        // next state for the states this block owns
        case (r_q.st)
            BSS_ST_INCIN: begin
                if (lock_go) begin
                    nx = BSS_ST_LOCKOUT;
                end else if (wait_go) begin
                    nx = BSS_ST_WAITING;
                end else if (cond.main_perm) begin
                    nx = bss_poff_to_wait(poff) ? BSS_ST_WAITING : BSS_ST_PILOT;
                end else if (cond.above_assist_off && clean) begin
                    nx = BSS_ST_INCIN_NA;
                end
            end
            BSS_ST_INCIN_NA: begin
                if (lock_go) begin
                    nx = BSS_ST_LOCKOUT;
                end else if (wait_go) begin
                    nx = BSS_ST_WAITING;
                end else if (cond.main_perm || cond.above_waste_off) begin
                    nx = bss_poff_to_wait(poff) ? BSS_ST_WAITING : BSS_ST_PILOT;
                end else if (!cond.above_assist_off && clean) begin
                    nx = BSS_ST_INCIN;
                end
            end
            BSS_ST_PID: begin
                if (lock_go) begin
                    nx = BSS_ST_LOCKOUT;
                end else if (wait_go) begin
                    nx = BSS_ST_WAITING;
                end else if (cond.main_perm || cond.above_low_fire_sp) begin
                    nx = bss_poff_to_wait(poff) ? BSS_ST_WAITING : BSS_ST_PILOT;
                end else if (!cond.below_process_sp && r_q.dly_cnt >= r_q.dly) begin
                    nx = r_q.ctrl[BSS_CTRL_LHS] ? BSS_ST_PILOT : BSS_ST_WAITING;
                end
            end
            BSS_ST_LOW_FIRE: begin
                if (cond.below_process_sp && r_q.ctrl[BSS_CTRL_AUXPID] && clean) begin
                    nx = BSS_ST_PID;
                end
            end
            default: begin
                nx = r_q.st;
            end
        endcase
        // the wider sequencer may place us in any state
        if (enter_valid && !(in_main || r_q.st == BSS_ST_INCIN || r_q.st == BSS_ST_LOW_FIRE)) begin
            nx = enter_state;
        end else if (enter_valid && r_q.st == nx) begin
            nx = enter_state;
        end
        r_d.st = nx;

        // standby delay counts only while in the band in pid
        if (nx == BSS_ST_PID && r_q.st == BSS_ST_PID && !cond.below_process_sp &&
                !cond.above_low_fire_sp) begin
            if (r_q.dly_cnt != 32'hFFFF_FFFF) begin
                r_d.dly_cnt = r_q.dly_cnt + 32'h0000_0001;
            end
        end else begin
            r_d.dly_cnt = 32'h0000_0000;
        end

        // safety outputs follow the next state so they change with it
        r_d.out = '0;
        if (nx == BSS_ST_INCIN_NA || nx == BSS_ST_PID || nx == BSS_ST_INCIN) begin
            r_d.out.pilot = 1'b1;
            r_d.out.card_valve = 1'b1;
            r_d.out.first_safety_shutoff_valve = nx != BSS_ST_INCIN_NA;
            r_d.out.second_safety_shutoff_valve = 1'b1;
            if (poff == BSS_POFF_AFTER_MAIN) begin
                r_d.out.pilot = 1'b0;
                r_d.out.card_valve = 1'b0;
            end
            // reignition: coil and uv contact under relight control
            r_d.out.ign_coil = r_q.ctrl[BSS_CTRL_REIGN];
            r_d.out.uv_ign_enable = r_q.ctrl[BSS_CTRL_REIGN];
        end

        // sticky events, set wins over clear
        if (acc && pwrite && paddr == BSS_IRQ_OFS) begin
            r_d.irq_st = r_q.irq_st & ~pwdata[BSS_IRQ_W-1:0];
        end
        if (nx != r_q.st) begin
            r_d.irq_st[BSS_IRQ_CHANGE] = 1'b1;
            if (nx == BSS_ST_LOCKOUT) begin
                r_d.irq_st[BSS_IRQ_LOCKOUT] = 1'b1;
            end
            if (nx == BSS_ST_WAITING) begin
                r_d.irq_st[BSS_IRQ_WAIT] = 1'b1;
            end
            if (nx == BSS_ST_PILOT) begin
                r_d.irq_st[BSS_IRQ_PILOT] = 1'b1;
            end
        end

        // apb: one wait state in the access phase, ready pulses once
        r_d.ready = acc;
        r_d.err = acc && !bss_mapped(paddr);
        r_d.rdata = 32'h0000_0000;
        if (acc && pwrite) begin
            case (paddr)
                BSS_CTRL_OFS: r_d.ctrl = pwdata;
                BSS_MASK_OFS: r_d.irq_mask = pwdata[BSS_IRQ_W-1:0];
                BSS_DLY_OFS: r_d.dly = pwdata;
                BSS_RELIGHT_OFS: r_d.relight_max = pwdata[3:0];
                default: r_d.err = acc && !bss_mapped(paddr);
            endcase
        end else if (acc) begin
            case (paddr)
                BSS_CTRL_OFS: r_d.rdata = {26'h0, r_q.ctrl[5:0]};
                BSS_STAT_OFS: r_d.rdata = {23'h0, r_q.out, r_q.st};
                BSS_IRQ_OFS: r_d.rdata = {28'h0, r_q.irq_st};
                BSS_MASK_OFS: r_d.rdata = {28'h0, r_q.irq_mask};
                BSS_DLY_OFS: r_d.rdata = r_q.dly;
                BSS_RELIGHT_OFS: r_d.rdata = {28'h0, r_q.relight_max};
                default: r_d.rdata = 32'h0000_0000;
            endcase
        end
        r_d.irq = |(r_d.irq_st & r_d.irq_mask);
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0;
            r_q.st <= BSS_ST_LOCKOUT;
            r_q.ctrl <= BSS_CTRL_RST;
            r_q.dly <= BSS_DLY_RST;
            r_q.relight_max <= BSS_RELIGHT_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs straight from flops
    assign prdata = r_q.rdata;
    assign pready = r_q.ready;
    assign pslverr = r_q.err;
    assign safety = r_q.out;
    assign state = r_q.st;
    assign irq = r_q.irq;

endmodule
`default_nettype wire

// >>> dv/bss_seq_properties.sv
// checker: sequencer moves and apb answer timing
`timescale 1ns/1ps
`default_nettype none
module bss_seq_properties
    import bss_pkg::*;
(
    // clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // sequencer
    input wire bss_cond_t cond,
    input wire bss_state_t state,
    input wire bss_out_t safety
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // no exit reason; a user stop may still force lockout, so lockout is allowed
    wire logic clean = !cond.alarm && !cond.wait_cond && !cond.main_perm && !cond.flame_loss;
    wire logic ours = state inside {BSS_ST_INCIN_NA, BSS_ST_PID};
    sequence s_take;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_apb_answer: assert property (s_take |=> s_answer)
        else $error("apb answer late or too long");
    a_na_valves: assert property (state == BSS_ST_INCIN_NA |->
        !safety.first_safety_shutoff_valve && safety.second_safety_shutoff_valve)
        else $error("no-assist valve drive wrong");
    a_pid_valves: assert property (state == BSS_ST_PID |->
        safety.first_safety_shutoff_valve && safety.second_safety_shutoff_valve)
        else $error("pid valve drive wrong");
    a_alarm_lock: assert property (ours && cond.alarm |=> state == BSS_ST_LOCKOUT)
        else $error("alarm did not lock out");
    a_wait_exit: assert property (ours && cond.wait_cond && !cond.alarm && !cond.flame_loss
        |=> state inside {BSS_ST_WAITING, BSS_ST_LOCKOUT})
        else $error("wait condition ignored");
    a_flame_lock: assert property (ours && cond.flame_loss &&
        cond.relight_count > BSS_RELIGHT_RST |=> state == BSS_ST_LOCKOUT)
        else $error("flame loss past limit not locked out");
    a_na_entry: assert property (state == BSS_ST_INCIN && cond.above_assist_off &&
        !cond.above_waste_off && clean |=> state inside {BSS_ST_INCIN_NA, BSS_ST_LOCKOUT})
        else $error("incinerate did not drop assist");
    a_na_return: assert property (state == BSS_ST_INCIN_NA && !cond.above_assist_off &&
        !cond.above_waste_off && clean |=> state inside {BSS_ST_INCIN, BSS_ST_LOCKOUT})
        else $error("no-assist did not return");
endmodule
bind bss_seq bss_seq_properties bss_seq_properties_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .cond(cond), .state(state),
    .safety(safety));
`default_nettype wire

// >>> dv/bss_burner_model.sv
// burner model: flame rides on main gas, lost on command
`timescale 1ns/1ps
`default_nettype none
module bss_burner_model
    import bss_pkg::*;
(
    // valve drive and test command
    input wire bss_out_t safety,
    input wire logic kill,
    // flame sensing
    output logic flame_loss
);
    // a flame can only be lost while gas flows through the second valve
    assign flame_loss = kill && safety.second_safety_shutoff_valve;
endmodule
`default_nettype wire

// >>> dv/tb_bss_seq.sv
// testbench for the incinerate-no-assist and pid sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_bss_seq;
    import bss_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, enter_valid, kill, fl;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_v, seed;
    logic err_v;
    bss_cond_t c_q, cond_w, c, q, qa, qp;
    bss_state_t enter_state, state, s;
    bss_out_t safety;
    int err_count, n_compared, cyc, n;
    bss_seq bss_seq_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cond(cond_w), .enter_valid(enter_valid),
        .enter_state(enter_state), .safety(safety), .state(state), .irq(irq));
    bss_burner_model bss_burner_model_i (.safety(safety), .kill(kill), .flame_loss(fl));
    // flame status comes from the burner, not from the stimulus
    always_comb begin
        cond_w = c_q;
        cond_w.flame_loss = fl;
    end
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        // let an edge pass so the previous release is never overwritten in one step
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
        end
        rd_v = prdata;
        err_v = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic ent(input bss_state_t st, input bss_cond_t cc);
        @(posedge pclk);
        c_q <= cc;
        enter_valid <= 1;
        enter_state <= st;
        @(posedge pclk);
        enter_valid <= 0;
        #1 chk(state, st);
    endtask
    task automatic app(input bss_cond_t cc, input logic k);
        @(posedge pclk);
        c_q <= cc;
        kill <= k;
        @(posedge pclk);
        kill <= 0;
        #1;
    endtask
    function automatic bss_out_t eo(input logic pid, input logic [1:0] m);
        eo = {m != BSS_POFF_AFTER_MAIN, pid, 1'b1, m != BSS_POFF_AFTER_MAIN, 2'b00};
    endfunction
    function automatic bss_state_t dm(input logic [1:0] m);
        dm = m[1] ? BSS_ST_WAITING : BSS_ST_PILOT;
    endfunction
    initial begin
        {presetn, psel, penable, pwrite, enter_valid, kill, paddr, pwdata} = '0;
        {c_q, q, err_count, n_compared, cyc} = '0;
        enter_state = BSS_ST_LOCKOUT;
        seed = 32'h93d0_14b7;
        qa = q;
        qa.above_assist_off = 1;
        qp = q;
        qp.below_process_sp = 1;
        repeat (4) @(posedge pclk);
        presetn <= 1;
        #1 chk(safety, 0);
        bus(0, BSS_CTRL_OFS, 0);
        chk(rd_v, BSS_CTRL_RST);
        bus(0, BSS_DLY_OFS, 0);
        chk(rd_v, BSS_DLY_RST);
        bus(0, BSS_RELIGHT_OFS, 0);
        chk(rd_v, 32'(BSS_RELIGHT_RST));
        bus(0, 8'h40, 0);
        chk(err_v, 1);
        bus(1, BSS_DLY_OFS, 32'h0000_0005);
        bus(1, BSS_MASK_OFS, 32'h0000_000F);
        // every pilot-off mode through both states
        for (int m = 0; m < 4; m++) begin
            bus(1, BSS_CTRL_OFS, 32'h0000_0009 | m << 1);
            ent(BSS_ST_INCIN, q);
            app(qa, 0);
            chk(state, BSS_ST_INCIN_NA);
            chk(safety, eo(0, 2'(m)));
            c = qa;
            c.above_waste_off = 1;
            app(c, 0);
            chk(state, dm(2'(m)));
            ent(BSS_ST_PID, qp);
            chk(safety, eo(1, 2'(m)));
            c = qp;
            c.main_perm = 1;
            app(c, 0);
            chk(state, dm(2'(m)));
            ent(BSS_ST_PID, qp);
            app(q, 0);
            c = q;
            c.above_low_fire_sp = 1;
            app(c, 0);
            chk(state, dm(2'(m)));
        end
        chk(irq, 1);
        ent(BSS_ST_INCIN_NA, qa);
        app(q, 0);
        chk(state, BSS_ST_INCIN);
        // exits by priority, in a randomly chosen state
        for (int k = 0; k < 8; k++) begin
            s = $random(seed) & 1 ? BSS_ST_PID : BSS_ST_INCIN_NA;
            c = s == BSS_ST_PID ? qp : qa;
            ent(s, c);
            c.relight_count = k > 3 ? 4'h4 : 4'h3;
            c.alarm = k % 4 == 0 || k % 4 == 2;
            c.wait_cond = k % 4 == 1 || k % 4 == 2;
            app(c, k % 4 == 3);
            chk(state, k % 4 == 1 || k == 3 ? BSS_ST_WAITING : BSS_ST_LOCKOUT);
        end
        ent(BSS_ST_PID, qp);
        bus(1, BSS_CTRL_OFS, 0);
        app(qp, 0);
        chk(state, BSS_ST_LOCKOUT);
        bus(1, BSS_CTRL_OFS, 32'h0000_0009);
        ent(BSS_ST_LOW_FIRE, q);
        app(qp, 0);
        chk(state, BSS_ST_PID);
        // reignition setting drives coil and uv contact
        bus(1, BSS_CTRL_OFS, 32'h0000_0029);
        @(posedge pclk);
        #1 chk(safety[1:0], 2'b11);
        // standby band, delay of five cycles, both standby modes
        for (int l = 0; l < 2; l++) begin
            bus(1, BSS_CTRL_OFS, 32'h0000_0009 | l << 4);
            ent(BSS_ST_PID, qp);
            app(q, 0);
            for (n = 0; n < 30 && state === BSS_ST_PID; n++) begin
                @(posedge pclk);
                #1;
            end
            chk(n >= 3, 1);
            chk(state, l ? BSS_ST_PILOT : BSS_ST_WAITING);
        end
        // interrupt: clear, masked event, then unmask
        ent(BSS_ST_PID, qp);
        bus(1, BSS_MASK_OFS, 0);
        bus(1, BSS_IRQ_OFS, 32'h0000_000F);
        bus(0, BSS_IRQ_OFS, 0);
        chk(rd_v, 0);
        chk(irq, 0);
        c = qp;
        c.alarm = 1;
        app(c, 0);
        chk(irq, 0);
        bus(0, BSS_IRQ_OFS, 0);
        chk(rd_v, 32'h0000_0009);
        bus(1, BSS_MASK_OFS, 32'h0000_0001);
        @(posedge pclk);
        #1 chk(irq, 1);
        final_report();
    end
endmodule
`default_nettype wire
